/* design/frps_pkg.sv */
// Package for the fault retry power sequencer: offsets, fields, timing
package frps_pkg;
	// Register indices, word access through the command port
	localparam logic [7:0] FRPS_ADDR_PG_ASSERT = 8'h5e;
	localparam logic [7:0] FRPS_ADDR_PG_NEGATE = 8'h5f;
	localparam logic [7:0] FRPS_ADDR_TURN_ON_DELAY_TIME = 8'h60;
	localparam logic [7:0] FRPS_ADDR_TURN_ON_RISE_TIME = 8'h61;
	localparam logic [7:0] FRPS_ADDR_FAULT_RESP = 8'h63;
	localparam logic [7:0] FRPS_ADDR_DELAY_UNIT = 8'hd2;
	localparam logic [7:0] FRPS_ADDR_STATUS = 8'hd3;
	// Reset values
	localparam logic [15:0] FRPS_RST_PG_ASSERT = 16'h0000;
	localparam logic [15:0] FRPS_RST_PG_NEGATE = 16'h0000;
	localparam logic [15:0] FRPS_RST_TURN_ON_DELAY_TIME = 16'h0000;
	localparam logic [15:0] FRPS_RST_TURN_ON_RISE_TIME = 16'h0001;
	localparam logic [7:0] FRPS_RST_FAULT_RESP = 8'h80;
	localparam logic [15:0] FRPS_RST_DELAY_UNIT = 16'h0001;
	// Fault response byte fields
	localparam int FRPS_RESP_MSB = 7;
	localparam int FRPS_RESP_LSB = 6;
	localparam int FRPS_RETRY_MSB = 5;
	localparam int FRPS_RETRY_LSB = 3;
	localparam int FRPS_TIME_MSB = 2;
	localparam int FRPS_TIME_LSB = 0;
	localparam logic [2:0] FRPS_RETRY_NONE = 3'h0;
	localparam logic [2:0] FRPS_RETRY_ENDLESS = 3'h7;
	// Status word bit positions
	localparam int FRPS_ST_PG_FLAG = 0;
	localparam int FRPS_ST_FAULT_LATCH = 1;
	localparam int FRPS_ST_OUT_ON = 2;
	localparam int FRPS_ST_PG_OUT = 3;
	// Timing: one millisecond of core clock at 10 MHz
	localparam int FRPS_CLK_HZ = 10000000;
	localparam int FRPS_MS_PER_S = 1000;
	localparam int FRPS_MS_CYCLES = FRPS_CLK_HZ / FRPS_MS_PER_S;
	typedef enum logic [1:0] {
		FRPS_RESP_IGNORE = 2'h0,
		FRPS_RESP_RUN_RETRY = 2'h1,
		FRPS_RESP_DIS_RETRY = 2'h2,
		FRPS_RESP_DIS_LATCH = 2'h3
	} frps_resp_t;
	typedef enum logic [5:0] {
		FRPS_ST_OFF = 6'h01,
		FRPS_ST_DELAY = 6'h02,
		FRPS_ST_RISE = 6'h04,
		FRPS_ST_ON = 6'h08,
		FRPS_ST_WAIT = 6'h10,
		FRPS_ST_LATCHED = 6'h20
	} frps_state_t;
endpackage

/* design/frps_ms_timer.sv */
// Millisecond-scaled down-counter timer
`timescale 1ns/1ps
`default_nettype none
module frps_ms_timer
	import frps_pkg::*;
#(
	parameter int MS_CYCLES = FRPS_MS_CYCLES
)(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Control
	input wire logic start,
	input wire logic [23:0] count_ms,
	// Result
	output logic done
);
	logic [23:0] ms_q, ms_d;
	logic [15:0] tick_q, tick_d;
	logic run_q, run_d;
	logic done_q, done_d;

	always_comb
	begin
		ms_d = ms_q;
		tick_d = tick_q;
		run_d = run_q;
		done_d = 1'b0;
		if (start)
		begin
			ms_d = count_ms;
			tick_d = 16'h0000;
			run_d = 1'b1;
		end
		else if (run_q)
		begin
			if (ms_q == 24'h000000)
			begin
				run_d = 1'b0;
				done_d = 1'b1;
			end
			else if (tick_q == 16'(MS_CYCLES - 1))
			begin
				tick_d = 16'h0000;
				ms_d = ms_q - 24'h000001;
			end
			else
				tick_d = tick_q + 16'h0001;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			ms_q <= 24'h000000;
			tick_q <= 16'h0000;
			run_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			ms_q <= ms_d;
			tick_q <= tick_d;
			run_q <= run_d;
			done_q <= done_d;
		end
	end

	assign done = done_q;
endmodule // frps_ms_timer
`default_nettype wire

/* design/frps_sequencer.sv */
// Fault retry policy, turn-on sequencing and power-good supervision
// Overview of operation
// - Retry field 110 gives six restart attempts
// - Exhausted attempts disable output until cleared
// - Attempt spacing is two to the time field times unit
// - Time field selects two to the value
// - Unit count is run delay or spacing
// - Unit length comes from separate register
// - Hold sixteen-bit power-good assert threshold
// - Below negate threshold drop enabled power-good
// - Below negate threshold set status flag
// - Wait turn-on delay before ramping
// - Ramp output over programmed rise time
// - Response mode selects ignore, run, disable
// - Retry field 000 means never restart
// - Clear, reset or off-on clears
`timescale 1ns/1ps
`default_nettype none
module frps_sequencer
	import frps_pkg::*;
#(
	parameter int MS_CYCLES = FRPS_MS_CYCLES
)(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register command port
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	input wire logic clear_faults,
	// Converter side
	input wire logic enable_pin,
	input wire logic fault_pin,
	input wire logic [15:0] vout_meas,
	input wire logic multi_pin_configuration,
	output logic output_enable,
	output logic ramp_active,
	output logic power_good_output
);
	// Pin synchronisers
	logic [1:0] en_sync_q, flt_sync_q;
	logic en_s, flt_s, en_prev_q;
	assign en_s = en_sync_q[1];
	assign flt_s = flt_sync_q[1];

	// Registers
	logic [15:0] power_good_assert_threshold_q;
	logic [15:0] power_good_negate_threshold_q;
	logic [15:0] turn_on_delay_time_q;
	logic [15:0] turn_on_rise_time_q;
	logic [7:0] fault_response_q;
	logic [15:0] delay_unit_ms_q;
	logic pg_flag_q, pg_flag_d;
	logic pg_q, pg_d;

	frps_state_t state_q, state_d;
	logic [2:0] tries_q, tries_d;
	logic tmr_start;
	logic [23:0] tmr_ms;
	logic tmr_done;
	logic fault_clr;

	frps_resp_t resp;
	logic [2:0] retry_lim, time_sel;
	logic [23:0] retry_ms;
	assign resp = frps_resp_t'(fault_response_q[FRPS_RESP_MSB:FRPS_RESP_LSB]);
	assign retry_lim = fault_response_q[FRPS_RETRY_MSB:FRPS_RETRY_LSB];
	assign time_sel = fault_response_q[FRPS_TIME_MSB:FRPS_TIME_LSB];
	// Units scale as a power of two; unit length from its own register
	assign retry_ms = 24'(delay_unit_ms_q) << time_sel;

	// Off then on through the enable pin, or clear command
	assign fault_clr = clear_faults || (en_s && !en_prev_q);

	frps_ms_timer #(
		.MS_CYCLES(MS_CYCLES)
	) u_timer (
		.core_clk(core_clk),
		.rst(rst),
		.start(tmr_start),
		.count_ms(tmr_ms),
		.done(tmr_done)
	);

	always_comb
	begin
		state_d = state_q;
		tries_d = tries_q;
		tmr_start = 1'b0;
		tmr_ms = 24'h000000;
		case (state_q)
			FRPS_ST_OFF:
				if (en_s)
				begin
					state_d = FRPS_ST_DELAY;
					tries_d = 3'h0;
					tmr_start = 1'b1;
					tmr_ms = 24'(turn_on_delay_time_q);
				end
			FRPS_ST_DELAY:
				if (!en_s)
					state_d = FRPS_ST_OFF;
				else if (tmr_done)
				begin
					state_d = FRPS_ST_RISE;
					tmr_start = 1'b1;
					tmr_ms = 24'(turn_on_rise_time_q);
				end
			FRPS_ST_RISE, FRPS_ST_ON:
				if (!en_s)
					state_d = FRPS_ST_OFF;
				else if (flt_s && resp != FRPS_RESP_IGNORE)
				begin
					// Run-through mode keeps output on while timing
					state_d = FRPS_ST_WAIT;
					tmr_start = 1'b1;
					tmr_ms = retry_ms;
					if (resp == FRPS_RESP_DIS_LATCH)
						state_d = FRPS_ST_LATCHED;
					else if (resp == FRPS_RESP_DIS_RETRY &&
						retry_lim == FRPS_RETRY_NONE)
						state_d = FRPS_ST_LATCHED;
				end
				else if (state_q == FRPS_ST_RISE && tmr_done)
					state_d = FRPS_ST_ON;
			FRPS_ST_WAIT:
				if (!en_s)
					state_d = FRPS_ST_OFF;
				else if (tmr_done)
				begin
					if (resp == FRPS_RESP_RUN_RETRY && !flt_s)
						state_d = FRPS_ST_ON;
					else if (retry_lim == FRPS_RETRY_NONE)
						state_d = FRPS_ST_LATCHED;
					else if (retry_lim != FRPS_RETRY_ENDLESS &&
						tries_q >= retry_lim)
						state_d = FRPS_ST_LATCHED;
					else
					begin
						// Endless mode never counts up to a limit
						if (retry_lim != FRPS_RETRY_ENDLESS)
							tries_d = tries_q + 3'h1;
						state_d = FRPS_ST_RISE;
						tmr_start = 1'b1;
						tmr_ms = 24'(turn_on_rise_time_q);
					end
				end
			FRPS_ST_LATCHED:
				if (fault_clr)
					state_d = FRPS_ST_OFF;
			default:
				state_d = FRPS_ST_OFF;
		endcase
	end

	always_comb
	begin
		pg_d = pg_q;
		pg_flag_d = pg_flag_q;
		if (vout_meas < power_good_negate_threshold_q)
		begin
			pg_d = 1'b0;
			pg_flag_d = 1'b1;
		end
		else if (vout_meas >= power_good_assert_threshold_q)
			pg_d = 1'b1;
		if (clear_faults && !pg_flag_d)
			pg_flag_d = 1'b0;
		else if (clear_faults &&
			!(vout_meas < power_good_negate_threshold_q))
			pg_flag_d = 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			en_sync_q <= 2'h0;
			flt_sync_q <= 2'h0;
			en_prev_q <= 1'b0;
			state_q <= FRPS_ST_OFF;
			tries_q <= 3'h0;
			pg_q <= 1'b0;
			pg_flag_q <= 1'b0;
			power_good_assert_threshold_q <= FRPS_RST_PG_ASSERT;
			power_good_negate_threshold_q <= FRPS_RST_PG_NEGATE;
			turn_on_delay_time_q <= FRPS_RST_TURN_ON_DELAY_TIME;
			turn_on_rise_time_q <= FRPS_RST_TURN_ON_RISE_TIME;
			fault_response_q <= FRPS_RST_FAULT_RESP;
			delay_unit_ms_q <= FRPS_RST_DELAY_UNIT;
		end
		else
		begin
			en_sync_q <= {en_sync_q[0], enable_pin};
			flt_sync_q <= {flt_sync_q[0], fault_pin};
			en_prev_q <= en_s;
			state_q <= state_d;
			tries_q <= tries_d;
			pg_q <= pg_d;
			pg_flag_q <= pg_flag_d;
			if (reg_wr)
				case (reg_addr)
					FRPS_ADDR_PG_ASSERT:
						power_good_assert_threshold_q <= reg_wdata;
					FRPS_ADDR_PG_NEGATE:
						power_good_negate_threshold_q <= reg_wdata;
					FRPS_ADDR_TURN_ON_DELAY_TIME:
						turn_on_delay_time_q <= reg_wdata;
					FRPS_ADDR_TURN_ON_RISE_TIME:
						turn_on_rise_time_q <= reg_wdata;
					FRPS_ADDR_FAULT_RESP:
						fault_response_q <= reg_wdata[7:0];
					FRPS_ADDR_DELAY_UNIT:
						delay_unit_ms_q <= reg_wdata;
					default:
						;
				endcase
		end
	end

	always_comb
	begin
		case (reg_addr)
			FRPS_ADDR_PG_ASSERT: reg_rdata = power_good_assert_threshold_q;
			FRPS_ADDR_PG_NEGATE: reg_rdata = power_good_negate_threshold_q;
			FRPS_ADDR_TURN_ON_DELAY_TIME: reg_rdata = turn_on_delay_time_q;
			FRPS_ADDR_TURN_ON_RISE_TIME: reg_rdata = turn_on_rise_time_q;
			FRPS_ADDR_FAULT_RESP: reg_rdata = {8'h00, fault_response_q};
			FRPS_ADDR_DELAY_UNIT: reg_rdata = delay_unit_ms_q;
			FRPS_ADDR_STATUS:
				reg_rdata = {12'h000, power_good_output, output_enable,
					state_q == FRPS_ST_LATCHED, pg_flag_q};
			default: reg_rdata = 16'h0000;
		endcase
	end

	assign output_enable = (state_q == FRPS_ST_RISE) ||
		(state_q == FRPS_ST_ON) ||
		(state_q == FRPS_ST_WAIT && resp == FRPS_RESP_RUN_RETRY);
	assign ramp_active = (state_q == FRPS_ST_RISE);
	// Pin stays low unless enabled in the multi-pin setting
	assign power_good_output = pg_q && multi_pin_configuration;

	a_latch_holds: assert property (@(posedge core_clk) disable iff (rst)
		state_q == FRPS_ST_LATCHED && !fault_clr |=> !output_enable)
		else $error("output on while latched");
	a_pg_negate: assert property (@(posedge core_clk) disable iff (rst)
		vout_meas < power_good_negate_threshold_q |=> !pg_q && pg_flag_q)
		else $error("power good not negated");
	a_pg_hyst: assert property (@(posedge core_clk) disable iff (rst)
		vout_meas >= power_good_negate_threshold_q &&
		vout_meas < power_good_assert_threshold_q |=> $stable(pg_q))
		else $error("power good moved inside band");
	a_pg_assert: assert property (@(posedge core_clk) disable iff (rst)
		vout_meas >= power_good_assert_threshold_q &&
		vout_meas >= power_good_negate_threshold_q |=> pg_q)
		else $error("power good not asserted");
	a_delay_rise: assert property (@(posedge core_clk) disable iff (rst)
		state_q == FRPS_ST_DELAY && tmr_done && en_s |=>
		state_q == FRPS_ST_RISE)
		else $error("ramp did not follow delay");
	a_tries_bound: assert property (@(posedge core_clk) disable iff (rst)
		retry_lim != FRPS_RETRY_ENDLESS && $changed(tries_q) &&
		tries_q != 3'h0 |-> tries_q <= retry_lim)
		else $error("too many retries");
	a_retry_none: assert property (@(posedge core_clk) disable iff (rst)
		state_q == FRPS_ST_WAIT && tmr_done && en_s && flt_s &&
		retry_lim == FRPS_RETRY_NONE |=> state_q == FRPS_ST_LATCHED)
		else $error("restart with zero retry");
	a_latch_mode: assert property (@(posedge core_clk) disable iff (rst)
		(state_q == FRPS_ST_ON) && en_s && flt_s &&
		resp == FRPS_RESP_DIS_LATCH |=> state_q == FRPS_ST_LATCHED)
		else $error("latch mode not applied");
	a_endless: assert property (@(posedge core_clk) disable iff (rst)
		retry_lim == FRPS_RETRY_ENDLESS && state_q == FRPS_ST_WAIT &&
		tmr_done && en_s && resp == FRPS_RESP_DIS_RETRY |=>
		state_q == FRPS_ST_RISE)
		else $error("endless retry stopped");
	a_clear: assert property (@(posedge core_clk) disable iff (rst)
		state_q == FRPS_ST_LATCHED && fault_clr |=> state_q == FRPS_ST_OFF)
		else $error("fault not cleared");
	c_turn_on: cover property (@(posedge core_clk) disable iff (rst)
		state_q == FRPS_ST_RISE ##1 state_q == FRPS_ST_ON);
	c_retry: cover property (@(posedge core_clk) disable iff (rst)
		state_q == FRPS_ST_WAIT ##1 state_q == FRPS_ST_RISE);
	c_latched: cover property (@(posedge core_clk) disable iff (rst)
		state_q == FRPS_ST_WAIT ##1 state_q == FRPS_ST_LATCHED);
	c_pg_drop: cover property (@(posedge core_clk) disable iff (rst)
		pg_q ##1 !pg_q);
endmodule // frps_sequencer
`default_nettype wire

/* sim/frps_power_stage.sv */
// Behavioural power stage and load facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module frps_power_stage (
	// Clock
	input wire logic core_clk,
	// Sequencer side
	input wire logic output_enable,
	output logic fault_pin,
	output logic [15:0] vout_meas,
	// Bench control
	input wire logic short_on,
	input wire logic [15:0] level
);
	logic [15:0] vout_q;
	// Collapsed output reads zero, so a load short vanishes once off
	always_ff @(posedge core_clk)
	begin
		vout_q <= output_enable ? level : 16'h0000;
	end
	assign vout_meas = vout_q;
	assign fault_pin = short_on & output_enable;
endmodule // frps_power_stage
`default_nettype wire

/* sim/frps_sequencer_tb.sv */
// Self-checking bench for the fault retry power sequencer
`timescale 1ns/1ps
`default_nettype none
module frps_sequencer_tb;
	import frps_pkg::*;
	logic core_clk, rst, reg_wr, clear_faults, enable_pin, fault_pin;
	logic multi_pin_configuration, output_enable, ramp_active;
	logic power_good_output, short_on;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, vout_meas, level;
	int mismatches, n_compared;
	frps_sequencer #(.MS_CYCLES(10)) frps_sequencer_inst (
		.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.clear_faults(clear_faults), .enable_pin(enable_pin),
		.fault_pin(fault_pin), .vout_meas(vout_meas),
		.multi_pin_configuration(multi_pin_configuration),
		.output_enable(output_enable), .ramp_active(ramp_active),
		.power_good_output(power_good_output));
	frps_power_stage frps_power_stage_inst (
		.core_clk(core_clk), .output_enable(output_enable),
		.fault_pin(fault_pin), .vout_meas(vout_meas),
		.short_on(short_on), .level(level));
	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge core_clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(negedge core_clk);
		reg_addr = a;
		#1 check(reg_rdata, exp);
	endtask
	// Counts output turn-ons seen across a window
	task automatic rises(input int n, output int r);
		logic p;
		p = output_enable;
		r = 0;
		repeat (n)
		begin
			@(negedge core_clk);
			if (output_enable === 1'b1 && p === 1'b0)
				r++;
			p = output_enable;
		end
	endtask
	task automatic wait_oe(input logic v, output int n);
		n = 0;
		while (output_enable !== v && n < 2000)
		begin
			@(negedge core_clk);
			n++;
		end
	endtask
	task automatic off_clear;
		enable_pin = 1'b0;
		short_on = 1'b0;
		cyc(5);
		clear_faults = 1'b1;
		cyc(1);
		clear_faults = 1'b0;
		cyc(5);
		@(negedge core_clk);
		reg_addr = FRPS_ADDR_STATUS;
		// Latch and output-on bits only; the flag may still be set
		#1 check(reg_rdata & 16'h0006, 16'h0000);
	endtask
	task automatic t_reset;
		rd(FRPS_ADDR_PG_ASSERT, 16'h0000);
		rd(FRPS_ADDR_TURN_ON_DELAY_TIME, 16'h0000);
		rd(FRPS_ADDR_TURN_ON_RISE_TIME, 16'h0001);
		rd(FRPS_ADDR_FAULT_RESP, 16'h0080);
		rd(FRPS_ADDR_DELAY_UNIT, 16'h0001);
		rd(8'h20, 16'h0000);
		wr(8'h20, 16'h1234);
		rd(8'h20, 16'h0000);
	endtask
	task automatic t_turn_on;
		int n;
		wr(FRPS_ADDR_TURN_ON_DELAY_TIME, 16'h0003);
		wr(FRPS_ADDR_TURN_ON_RISE_TIME, 16'h0002);
		rd(FRPS_ADDR_TURN_ON_DELAY_TIME, 16'h0003);
		enable_pin = 1'b1;
		wait_oe(1'b1, n);
		check(n >= 30 && n <= 36, 1);
		n = 0;
		while (ramp_active === 1'b1 && n < 100)
		begin
			@(negedge core_clk);
			n++;
		end
		check(n >= 19 && n <= 22, 1);
		off_clear();
		wr(FRPS_ADDR_TURN_ON_DELAY_TIME, 16'h0000);
	endtask
	// Persistent short: initial start plus the permitted restarts
	task automatic t_retry(input logic [7:0] resp, input int exp,
		input logic lat);
		int r;
		wr(FRPS_ADDR_FAULT_RESP, {8'h00, resp});
		short_on = 1'b1;
		enable_pin = 1'b1;
		rises(1200, r);
		if (exp > 7)
			check(r > 7, 1);
		else
			check(r, exp);
		@(negedge core_clk);
		reg_addr = FRPS_ADDR_STATUS;
		#1 check(reg_rdata & 16'h0002, {14'h0, lat, 1'b0});
		if (exp > 7)
		begin
			// Endless retry may be between attempts; expect another one
			rises(40, r);
			check(r > 0, 1);
		end
		else
			check(output_enable, !lat);
		off_clear();
	endtask
	task automatic t_spacing;
		int n;
		wr(FRPS_ADDR_DELAY_UNIT, 16'h0002);
		wr(FRPS_ADDR_FAULT_RESP, 16'h0089);
		short_on = 1'b1;
		enable_pin = 1'b1;
		wait_oe(1'b1, n);
		cyc(1);
		wait_oe(1'b0, n);
		wait_oe(1'b1, n);
		check(n >= 40 && n <= 46, 1);
		off_clear();
		wr(FRPS_ADDR_DELAY_UNIT, 16'h0001);
	endtask
	task automatic pg(input logic [15:0] v, input logic exp);
		level = v;
		cyc(6);
		check(power_good_output, exp);
	endtask
	task automatic t_power_good;
		int n;
		wr(FRPS_ADDR_FAULT_RESP, 16'h0000);
		wr(FRPS_ADDR_PG_ASSERT, 16'h0064);
		wr(FRPS_ADDR_PG_NEGATE, 16'h0032);
		rd(FRPS_ADDR_PG_NEGATE, 16'h0032);
		multi_pin_configuration = 1'b1;
		enable_pin = 1'b1;
		wait_oe(1'b1, n);
		cyc(20);
		pg(16'h0078, 1'b1);
		pg(16'h0046, 1'b1);
		pg(16'h0064, 1'b1);
		pg(16'h001e, 1'b0);
		@(negedge core_clk);
		reg_addr = FRPS_ADDR_STATUS;
		#1 check(reg_rdata & 16'h0001, 16'h0001);
		pg(16'h0063, 1'b0);
		pg(16'h0064, 1'b1);
		multi_pin_configuration = 1'b0;
		pg(16'h0078, 1'b0);
		off_clear();
	endtask
	initial
	begin
		repeat (20000) @(posedge core_clk);
		mismatches++;
		results();
	end
	initial
	begin
		{rst, reg_wr, clear_faults, enable_pin, short_on} = 5'b10000;
		multi_pin_configuration = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		level = 16'h0078;
		mismatches = 0;
		n_compared = 0;
		cyc(16);
		rst = 1'b0;
		t_reset();
		t_turn_on();
		t_retry(8'hb0, 7, 1'b1);
		t_retry(8'h80, 1, 1'b1);
		t_retry(8'hf0, 1, 1'b1);
		t_retry(8'h30, 1, 1'b0);
		t_retry(8'hb8, 99, 1'b0);
		t_spacing();
		t_power_good();
		results();
	end
endmodule // frps_sequencer_tb
`default_nettype wire
